/* File: design/pml_map.svh */
`ifndef PML_MAP_SVH
`define PML_MAP_SVH

// widths of the shared address/data lines and of one data word
`define PML_DAL_W              22
`define PML_WORD_W             16
`define PML_CNT_W              8

// clock period of SYS_CLK
`define PML_CLK_PERIOD_NS      10

// write timing, all least times
`define PML_DATA_DELAY_NS      80
`define PML_STB_DELAY_NS       75
`define PML_STB_HOLD_NS        30

// read timing: second word settles this long after the strobe ends
`define PML_WORD2_NS           58

// address phase, plus the read strobe timeout
`define PML_ADDR_SETUP_NS      20
`define PML_ADDR_HOLD_NS       20
`define PML_SEL_WAIT_NS        200
`define PML_STB_TIMEOUT_NS     2000

// qualifier codes {write_byte_qualifier, byte_qualifier}, 1 = asserted
`define PML_QUAL_WORD_READ     2'h0
`define PML_QUAL_READ_PAUSE    2'h1
`define PML_QUAL_WORD_WRITE    2'h2
`define PML_QUAL_BYTE_WRITE    2'h3

// bit positions inside the synchronised pin vector
`define PML_SV_SYNC            0
`define PML_SV_REPLY           1
`define PML_SV_WBF             2
`define PML_SV_RSTB            3
`define PML_SV_UBMEM           4
`define PML_SV_SSEL            5
`define PML_SV_PLO             6
`define PML_SV_PHI             7
`define PML_SV_DAL             8
`define PML_SV_W               30

`endif

/* File: design/pml_pkg.sv */
`include "pml_map.svh"

package pml_pkg;

  typedef enum logic [1:0] {
    PML_WORD_READ_CYCLE  = 2'h0,
    PML_READ_PAUSE_CYCLE = 2'h1,
    PML_WORD_WRITE_CYCLE = 2'h2,
    PML_BYTE_WRITE_CYCLE = 2'h3
  } pml_cyc_t;

  typedef enum logic [1:0] {
    PML_PREV_NONE          = 2'h0,
    PML_PREV_OWN_SHARED    = 2'h1,
    PML_PREV_INTR_SERVICE  = 2'h2,
    PML_PREV_OTHER_MASTER  = 2'h3
  } pml_prev_t;

  typedef enum logic [3:0] {
    PML_ST_IDLE   = 4'h0,
    PML_ST_ARB    = 4'h1,
    PML_ST_ADDR   = 4'h3,
    PML_ST_SEL    = 4'h2,
    PML_ST_HOLD   = 4'h6,
    PML_ST_RD_HI  = 4'h7,
    PML_ST_RD_LO  = 4'h5,
    PML_ST_RD_W2  = 4'h4,
    PML_ST_WR_DAT = 4'hE,
    PML_ST_WR_STB = 4'hA,
    PML_ST_WR_END = 4'hB
  } pml_state_t;

  typedef struct packed {
    pml_cyc_t                   kind;
    logic                       io_page;
    logic [`PML_DAL_W-1:0]      addr;
    logic [`PML_WORD_W-1:0]     wdata;
  } pml_req_t;

  typedef struct packed {
    logic [`PML_WORD_W-1:0]     word0;
    logic [`PML_WORD_W-1:0]     word1;
    logic                       par_err;
  } pml_rsp_t;

endpackage : pml_pkg

/* File: design/pml_sync2.sv */
`timescale 1ns/10ps

// two-stage synchroniser, one pair of flops per bit
module pml_sync2 #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta;

  genvar i;
  generate
    for (i = 0; i < W; i++)
    begin : g_bit
      always_ff @(posedge clk or negedge rst_n)
      begin
        if (!rst_n)
        begin
          meta[i] <= 1'b0;
          q[i]    <= 1'b0;
        end
        else
        begin
          meta[i] <= d[i];
          q[i]    <= meta[i];
        end
      end
    end
  endgenerate

endmodule : pml_sync2

/* File: design/pml_host.sv */
`timescale 1ns/10ps
`include "pml_map.svh"

module pml_host #(
  parameter int SEL_WAIT_NS    = `PML_SEL_WAIT_NS,
  parameter int STB_TIMEOUT_NS = `PML_STB_TIMEOUT_NS
) (
  input  wire logic                    SYS_CLK,
  input  wire logic                    RESET_N,
  input  wire logic                    REQ_VALID,
  input  wire pml_pkg::pml_req_t       REQ,
  input  wire pml_pkg::pml_prev_t      PREV_KIND,
  output pml_pkg::pml_rsp_t            RSP,
  output logic                         READY,
  output logic                         DONE,
  output logic                         FALLBACK,
  output logic                         TIMEOUT,
  input  wire logic [`PML_DAL_W-1:0]   DAL_IN,
  output logic      [`PML_DAL_W-1:0]   DAL_OUT,
  output logic                         DAL_OE,
  output logic                         IO_PAGE_SELECT,
  output logic                         WRITE_BYTE_QUALIFIER,
  output logic                         BYTE_QUALIFIER,
  output logic                         PRIVATE_CYCLE_ACTIVE,
  output logic                         WRITE_STROBE,
  input  wire logic                    SLAVE_SELECTED_IN,
  input  wire logic                    OTHER_BUS_MEMORY_RESPONDING,
  input  wire logic                    READ_STROBE,
  input  wire logic                    WRITE_BUFFER_FULL,
  input  wire logic                    BUS_REPLY,
  input  wire logic                    BUS_SYNC,
  input  wire logic                    HIGH_BYTE_PARITY,
  input  wire logic                    LOW_BYTE_PARITY
);

  localparam int CLK_NS = `PML_CLK_PERIOD_NS;
  localparam logic [`PML_CNT_W-1:0] ADDR_SETUP =
    `PML_CNT_W'((`PML_ADDR_SETUP_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [`PML_CNT_W-1:0] ADDR_HOLD =
    `PML_CNT_W'((`PML_ADDR_HOLD_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [`PML_CNT_W-1:0] DATA_DLY =
    `PML_CNT_W'((`PML_DATA_DELAY_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [`PML_CNT_W-1:0] STB_DLY =
    `PML_CNT_W'((`PML_STB_DELAY_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [`PML_CNT_W-1:0] STB_HOLD =
    `PML_CNT_W'((`PML_STB_HOLD_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [`PML_CNT_W-1:0] WORD2_DLY =
    `PML_CNT_W'((`PML_WORD2_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [`PML_CNT_W-1:0] SEL_WAIT =
    `PML_CNT_W'(SEL_WAIT_NS / CLK_NS);
  localparam logic [`PML_CNT_W-1:0] STB_TIMEOUT =
    `PML_CNT_W'(STB_TIMEOUT_NS / CLK_NS);
  localparam logic [`PML_CNT_W-1:0] ONE = `PML_CNT_W'(1);

  // every pin input, data lines included, shares one synchroniser so the
  // read strobe and the word it marks arrive with the same latency
  logic [`PML_SV_W-1:0] sv;

  pml_sync2 #(
    .W (`PML_SV_W)
  ) u_sync (
    .clk   (SYS_CLK),
    .rst_n (RESET_N),
    .d     ({DAL_IN, HIGH_BYTE_PARITY, LOW_BYTE_PARITY, SLAVE_SELECTED_IN,
             OTHER_BUS_MEMORY_RESPONDING, READ_STROBE, WRITE_BUFFER_FULL,
             BUS_REPLY, BUS_SYNC}),
    .q     (sv)
  );

  logic                    sync_s;
  logic                    reply_s;
  logic                    wbf_s;
  logic                    rstb_s;
  logic                    ubmem_s;
  logic                    ssel_s;
  logic [`PML_WORD_W-1:0]  word_s;
  logic                    par_bad;

  assign sync_s  = sv[`PML_SV_SYNC];
  assign reply_s = sv[`PML_SV_REPLY];
  assign wbf_s   = sv[`PML_SV_WBF];
  assign rstb_s  = sv[`PML_SV_RSTB];
  assign ubmem_s = sv[`PML_SV_UBMEM];
  assign ssel_s  = sv[`PML_SV_SSEL];
  assign word_s  = sv[`PML_SV_DAL +: `PML_WORD_W];
  // odd parity over the high byte, even over the low byte
  assign par_bad = ~(^{word_s[15:8], sv[`PML_SV_PHI]}) | (^{word_s[7:0], sv[`PML_SV_PLO]});

  pml_pkg::pml_state_t     state;
  pml_pkg::pml_state_t     next_state;
  logic [`PML_CNT_W-1:0]   cnt;
  logic [`PML_CNT_W-1:0]   next_cnt;
  pml_pkg::pml_req_t       req;
  pml_pkg::pml_req_t       next_req;
  pml_pkg::pml_prev_t      prev;
  pml_pkg::pml_prev_t      next_prev;
  pml_pkg::pml_rsp_t       next_rsp;
  logic [`PML_DAL_W-1:0]   next_dal_out;
  logic                    next_dal_oe;
  logic                    next_io;
  logic                    next_wbq;
  logic                    next_bq;
  logic                    next_pcyc;
  logic                    next_wstb;
  logic                    next_ready;
  logic                    next_done;
  logic                    next_fallback;
  logic                    next_timeout;
  logic                    arb_clear;
  logic                    abandon;
  logic [1:0]              qual;

  always_comb
  begin
    case (prev)
      pml_pkg::PML_PREV_OWN_SHARED:   arb_clear = !sync_s && !reply_s;
      pml_pkg::PML_PREV_INTR_SERVICE: arb_clear = !reply_s;
      pml_pkg::PML_PREV_OTHER_MASTER: arb_clear = !sync_s;
      default:                        arb_clear = 1'b1;
    endcase
    arb_clear = arb_clear && !wbf_s;
  end

  always_comb
  begin
    case (req.kind)
      pml_pkg::PML_READ_PAUSE_CYCLE: qual = `PML_QUAL_READ_PAUSE;
      pml_pkg::PML_WORD_WRITE_CYCLE: qual = `PML_QUAL_WORD_WRITE;
      pml_pkg::PML_BYTE_WRITE_CYCLE: qual = `PML_QUAL_BYTE_WRITE;
      default:                       qual = `PML_QUAL_WORD_READ;
    endcase
  end

  // once the write strobe has fired the data is committed, so loss of
  // slave-selected is only honoured up to that point
  assign abandon = PRIVATE_CYCLE_ACTIVE && !ssel_s &&
                   (state == pml_pkg::PML_ST_HOLD  || state == pml_pkg::PML_ST_RD_HI ||
                    state == pml_pkg::PML_ST_RD_LO || state == pml_pkg::PML_ST_RD_W2 ||
                    state == pml_pkg::PML_ST_WR_DAT);

  always_comb
  begin
    logic drop;
    drop          = 1'b0;
    next_state    = state;
    next_cnt      = cnt + ONE;
    next_req      = req;
    next_prev     = prev;
    next_rsp      = RSP;
    next_dal_out  = DAL_OUT;
    next_dal_oe   = DAL_OE;
    next_io       = IO_PAGE_SELECT;
    next_wbq      = WRITE_BYTE_QUALIFIER;
    next_bq       = BYTE_QUALIFIER;
    next_pcyc     = PRIVATE_CYCLE_ACTIVE;
    next_wstb     = WRITE_STROBE;
    next_ready    = READY;
    next_done     = 1'b0;
    next_fallback = 1'b0;
    next_timeout  = 1'b0;
    if (abandon)
    begin
      drop          = 1'b1;
      next_fallback = 1'b1;
    end
    else
    begin
      case (state)
        pml_pkg::PML_ST_IDLE:
          if (REQ_VALID)
          begin
            next_req   = REQ;
            next_prev  = PREV_KIND;
            next_rsp   = '0;
            next_ready = 1'b0;
            next_state = pml_pkg::PML_ST_ARB;
          end
        pml_pkg::PML_ST_ARB:
          if (arb_clear)
          begin
            next_dal_out          = req.addr;
            next_dal_oe           = 1'b1;
            next_io               = req.io_page;
            {next_wbq, next_bq}   = qual;
            next_cnt              = '0;
            next_state            = pml_pkg::PML_ST_ADDR;
          end
        pml_pkg::PML_ST_ADDR:
          if (cnt == ADDR_SETUP - ONE)
          begin
            next_cnt   = '0;
            next_state = pml_pkg::PML_ST_SEL;
          end
        pml_pkg::PML_ST_SEL:
          if (ssel_s && !ubmem_s)
          begin
            next_pcyc  = 1'b1;
            next_cnt   = '0;
            next_state = pml_pkg::PML_ST_HOLD;
          end
          else if (cnt == SEL_WAIT - ONE)
          begin
            drop          = 1'b1;
            next_fallback = 1'b1;
          end
        pml_pkg::PML_ST_HOLD:
          // address, page select and write-byte stay driven past the rise
          if (!WRITE_BYTE_QUALIFIER && cnt == ADDR_HOLD - ONE)
          begin
            next_dal_oe = 1'b0;
            next_bq     = 1'b0;
            next_cnt    = '0;
            next_state  = pml_pkg::PML_ST_RD_HI;
          end
          else if (WRITE_BYTE_QUALIFIER && cnt == DATA_DLY - ONE)
          begin
            next_dal_out = `PML_DAL_W'(req.wdata);
            next_bq      = 1'b0;
            next_cnt     = '0;
            next_state   = pml_pkg::PML_ST_WR_DAT;
          end
        pml_pkg::PML_ST_RD_HI:
          if (rstb_s)
          begin
            next_cnt   = '0;
            next_state = pml_pkg::PML_ST_RD_LO;
          end
          else if (cnt == STB_TIMEOUT - ONE)
          begin
            drop         = 1'b1;
            next_timeout = 1'b1;
          end
        pml_pkg::PML_ST_RD_LO:
          if (!rstb_s)
          begin
            next_rsp.word0   = word_s;
            next_rsp.par_err = par_bad;
            next_cnt         = '0;
            next_state       = pml_pkg::PML_ST_RD_W2;
          end
          else if (cnt == STB_TIMEOUT - ONE)
          begin
            drop         = 1'b1;
            next_timeout = 1'b1;
          end
        pml_pkg::PML_ST_RD_W2:
          if (cnt == WORD2_DLY - ONE)
          begin
            next_rsp.word1   = word_s;
            next_rsp.par_err = RSP.par_err | par_bad;
            next_done        = 1'b1;
            drop             = 1'b1;
          end
        pml_pkg::PML_ST_WR_DAT:
          if (cnt == STB_DLY - ONE)
          begin
            next_wstb  = 1'b1;
            next_cnt   = '0;
            next_state = pml_pkg::PML_ST_WR_STB;
          end
        pml_pkg::PML_ST_WR_STB:
          if (cnt == STB_HOLD - ONE)
          begin
            next_wstb  = 1'b0;
            next_state = pml_pkg::PML_ST_WR_END;
          end
        pml_pkg::PML_ST_WR_END:
        begin
          next_done = 1'b1;
          drop      = 1'b1;
        end
        default:
          drop = 1'b1;
      endcase
    end
    if (drop)
    begin
      next_state  = pml_pkg::PML_ST_IDLE;
      next_pcyc   = 1'b0;
      next_wstb   = 1'b0;
      next_dal_oe = 1'b0;
      next_io     = 1'b0;
      next_wbq    = 1'b0;
      next_bq     = 1'b0;
      next_ready  = 1'b1;
    end
  end

  always_ff @(posedge SYS_CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      state                <= pml_pkg::PML_ST_IDLE;
      cnt                  <= '0;
      req                  <= '0;
      prev                 <= pml_pkg::PML_PREV_NONE;
      RSP                  <= '0;
      DAL_OUT              <= '0;
      DAL_OE               <= 1'b0;
      IO_PAGE_SELECT       <= 1'b0;
      WRITE_BYTE_QUALIFIER <= 1'b0;
      BYTE_QUALIFIER       <= 1'b0;
      PRIVATE_CYCLE_ACTIVE <= 1'b0;
      WRITE_STROBE         <= 1'b0;
      READY                <= 1'b1;
      DONE                 <= 1'b0;
      FALLBACK             <= 1'b0;
      TIMEOUT              <= 1'b0;
    end
    else
    begin
      state                <= next_state;
      cnt                  <= next_cnt;
      req                  <= next_req;
      prev                 <= next_prev;
      RSP                  <= next_rsp;
      DAL_OUT              <= next_dal_out;
      DAL_OE               <= next_dal_oe;
      IO_PAGE_SELECT       <= next_io;
      WRITE_BYTE_QUALIFIER <= next_wbq;
      BYTE_QUALIFIER       <= next_bq;
      PRIVATE_CYCLE_ACTIVE <= next_pcyc;
      WRITE_STROBE         <= next_wstb;
      READY                <= next_ready;
      DONE                 <= next_done;
      FALLBACK             <= next_fallback;
      TIMEOUT              <= next_timeout;
    end
  end

  default clocking cb @(posedge SYS_CLK);
  endclocking
  default disable iff (!RESET_N);

  chk_cycle_code: assert property (state == pml_pkg::PML_ST_SEL |->
    {WRITE_BYTE_QUALIFIER, BYTE_QUALIFIER} == 2'(req.kind))
    else $error("cycle qualifiers do not match the requested cycle");
  chk_own_wait: assert property (
    state == pml_pkg::PML_ST_ARB && prev == pml_pkg::PML_PREV_OWN_SHARED &&
    (sync_s || reply_s) |=> state == pml_pkg::PML_ST_ARB)
    else $error("address phase began before own sync and reply were low");
  chk_other_wait: assert property (
    state == pml_pkg::PML_ST_ARB && prev == pml_pkg::PML_PREV_OTHER_MASTER && sync_s
    |=> !DAL_OE)
    else $error("address phase began while other master sync was high");
  chk_pcyc_select: assert property ($rose(PRIVATE_CYCLE_ACTIVE) |->
    $past(ssel_s) && !$past(ubmem_s))
    else $error("private cycle raised without slave selected");
  chk_pcyc_addr: assert property ($rose(PRIVATE_CYCLE_ACTIVE) |->
    DAL_OE && $past(DAL_OE, 2) ##1 DAL_OE && $stable(WRITE_BYTE_QUALIFIER))
    else $error("address not driven around private cycle rise");
  chk_sel_loss: assert property (abandon |=> !PRIVATE_CYCLE_ACTIVE && FALLBACK)
    else $error("private cycle kept after slave selected was lost");
  chk_word2_end: assert property (
    state == pml_pkg::PML_ST_RD_W2 && cnt == WORD2_DLY - ONE && ssel_s
    |=> !PRIVATE_CYCLE_ACTIVE && DONE && RSP.word1 == $past(word_s))
    else $error("private cycle not ended with second word latch");
  chk_word1_latch: assert property (
    state == pml_pkg::PML_ST_RD_LO && !rstb_s && ssel_s |=> RSP.word0 == $past(word_s))
    else $error("first word not latched on strobe negation");
  chk_strobe_order: assert property (WRITE_STROBE |-> PRIVATE_CYCLE_ACTIVE)
    else $error("write strobe high without private cycle");
  chk_write_timing: assert property (
    $rose(PRIVATE_CYCLE_ACTIVE) && WRITE_BYTE_QUALIFIER && ssel_s ##1 ssel_s[*8] ##1 ssel_s[*7]
    |=> WRITE_STROBE[*3] ##1 !WRITE_STROBE ##1 !PRIVATE_CYCLE_ACTIVE)
    else $error("write strobe timing wrong");
  chk_wbf_block: assert property (
    state == pml_pkg::PML_ST_ARB && wbf_s |=> state == pml_pkg::PML_ST_ARB)
    else $error("cycle started while write buffer full");

endmodule : pml_host

/* File: dv/pml_mem_model.sv */
`timescale 1ns/10ps
`include "pml_map.svh"

module pml_mem_model (
  input  wire logic                  clk,
  input  wire logic                  rst_n,
  input  wire logic [`PML_DAL_W-1:0] dal_out,
  input  wire logic                  dal_oe,
  input  wire logic                  wbq,
  input  wire logic                  bq,
  input  wire logic                  pca,
  input  wire logic                  wstb,
  input  wire logic                  drop_sel,
  input  wire logic                  no_stb,
  input  wire logic                  bad_par,
  input  wire logic [4:0]            busy,
  output logic      [`PML_DAL_W-1:0] dal_in,
  output logic                       ssel,
  output logic                       rstb,
  output logic                       wbf,
  output logic                       reply,
  output logic                       hbp,
  output logic                       lbp,
  output logic      [1:0]            cap_code,
  output logic      [15:0]           cap_data,
  output logic      [7:0]            viol
);
  logic [`PML_DAL_W-1:0] a;
  logic                  hit;
  logic                  drv;
  logic                  pca_q;
  logic                  wstb_q;
  logic [5:0]            cnt;
  logic [2:0]            st;

  function automatic logic [15:0] wd(input logic [`PML_DAL_W-1:0] x);
    return x[15:0] ^ 16'hA5C3;
  endfunction : wd

  // upper half of the map is not ours; drop_sel withdraws once the cycle is on
  assign ssel = hit & ~(drop_sel & pca);
  assign hbp  = bad_par ^ ~^dal_in[15:8];
  assign lbp  = ^dal_in[7:0];

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      {a, hit, drv, pca_q, wstb_q, cnt, st, rstb, wbf, reply} <= '0;
      {cap_code, cap_data, viol, dal_in} <= '0;
    end
    else
    begin
      pca_q  <= pca;
      wstb_q <= wstb;
      // released lines never hold the last value
      if (!drv)
        dal_in <= ~dal_in;
      if (!pca)
        hit <= dal_oe & ~dal_out[21];
      if (dal_oe & !pca)
      begin
        a        <= dal_out;
        cap_code <= {wbq, bq};
      end
      if (wbf && pca && !pca_q)
        viol <= viol + 8'h01;
      case (st)
        3'h0:
          if (pca && !pca_q && hit)
          begin
            cnt <= '0;
            if (wbq)
            begin
              reply <= 1'b1;
              st    <= 3'h4;
            end
            else
            begin
              dal_in <= wd(a);
              drv    <= 1'b1;
              st     <= 3'h1;
            end
          end
        3'h1:
        begin
          cnt <= cnt + 6'h01;
          if (cnt == 6'h29 && !no_stb)
          begin
            rstb <= 1'b1;
            cnt  <= '0;
            st   <= 3'h2;
          end
        end
        3'h2:
        begin
          cnt <= cnt + 6'h01;
          if (cnt == 6'h05)
          begin
            rstb <= 1'b0;
            st   <= 3'h6;
          end
        end
        // second word lands one cycle after the strobe falls, so a latch on
        // the falling strobe still catches the first word
        3'h6:
        begin
          dal_in <= wd(a ^ 22'h000002);
          st     <= 3'h3;
        end
        3'h4:
        begin
          if (wstb && !wstb_q)
          begin
            wbf      <= 1'b1;
            cap_data <= dal_out[15:0];
          end
          if (!pca)
            st <= 3'h5;
        end
        3'h5:
        begin
          cnt <= cnt + 6'h01;
          if (cnt >= {1'b0, busy})
          begin
            wbf   <= 1'b0;
            reply <= 1'b0;
            st    <= 3'h0;
          end
        end
        default: ;
      endcase
      if (st inside {3'h1, 3'h2, 3'h3, 3'h6} && !pca)
      begin
        drv  <= 1'b0;
        rstb <= 1'b0;
        st   <= 3'h0;
      end
    end
  end
endmodule : pml_mem_model

/* File: dv/pml_host_tb_top.sv */
`timescale 1ns/10ps
`include "pml_map.svh"

module pml_host_tb_top;
  logic                  clk, rst_n, req_valid, ubmem, sh_sync, sh_reply;
  logic                  drop_sel, no_stb, bad_par;
  logic [4:0]            busy;
  pml_pkg::pml_req_t     req;
  pml_pkg::pml_prev_t    prev;
  pml_pkg::pml_rsp_t     rsp;
  logic                  ready, done, fb, tmo, oe, iop, wbq, bq, pca, wstb;
  logic                  ssel, rstb, wbf, reply, hbp, lbp;
  logic [`PML_DAL_W-1:0] dal_o, dal_i;
  logic [1:0]            cap_code;
  logic [15:0]           cap_data;
  logic [7:0]            viol;
  int                    miscompares, samples_checked;

  pml_host pml_host_inst (.SYS_CLK(clk), .RESET_N(rst_n), .REQ_VALID(req_valid),
    .REQ(req), .PREV_KIND(prev), .RSP(rsp), .READY(ready), .DONE(done),
    .FALLBACK(fb), .TIMEOUT(tmo), .DAL_IN(dal_i), .DAL_OUT(dal_o), .DAL_OE(oe),
    .IO_PAGE_SELECT(iop), .WRITE_BYTE_QUALIFIER(wbq), .BYTE_QUALIFIER(bq),
    .PRIVATE_CYCLE_ACTIVE(pca), .WRITE_STROBE(wstb), .SLAVE_SELECTED_IN(ssel),
    .OTHER_BUS_MEMORY_RESPONDING(ubmem), .READ_STROBE(rstb), .WRITE_BUFFER_FULL(wbf),
    .BUS_REPLY(reply | sh_reply), .BUS_SYNC(sh_sync), .HIGH_BYTE_PARITY(hbp),
    .LOW_BYTE_PARITY(lbp));

  pml_mem_model pml_mem_model_inst (.clk(clk), .rst_n(rst_n), .dal_out(dal_o),
    .dal_oe(oe), .wbq(wbq), .bq(bq), .pca(pca), .wstb(wstb), .drop_sel(drop_sel),
    .no_stb(no_stb), .bad_par(bad_par), .busy(busy), .dal_in(dal_i), .ssel(ssel),
    .rstb(rstb), .wbf(wbf), .reply(reply), .hbp(hbp), .lbp(lbp),
    .cap_code(cap_code), .cap_data(cap_data), .viol(viol));

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  function automatic logic [15:0] exp_word(input logic [`PML_DAL_W-1:0] x);
    return x[15:0] ^ 16'hA5C3;
  endfunction : exp_word

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      miscompares++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp

  task automatic finish_test;
    $display("checked=%0d miscompares=%0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : finish_test

  // er: 0 done, 1 fallback, 2 timeout; hold keeps the shared bus busy first unless pv is 0
  task automatic op(input logic [1:0] k, input logic [21:0] ad, input logic [15:0] d,
                    input logic [1:0] pv, input int hold, input int er);
    int n;
    logic io_seen;
    n = 0;
    io_seen = 1'b0;
    while (!ready && n < 100)
    begin
      @(negedge clk);
      n++;
    end
    sh_sync  <= (hold > 0) && (pv == 2'h1 || pv == 2'h3);
    sh_reply <= (hold > 0) && (pv == 2'h1 || pv == 2'h2);
    @(negedge clk);
    req_valid   <= 1'b1;
    req.kind    <= pml_pkg::pml_cyc_t'(k);
    req.io_page <= ad[3];
    req.addr    <= ad;
    req.wdata   <= d;
    prev        <= pml_pkg::pml_prev_t'(pv);
    @(negedge clk);
    req_valid <= 1'b0;
    repeat (hold)
    begin
      @(negedge clk);
      if (pv != 2'h0)
        cmp(pca, 1'b0);
    end
    sh_sync  <= 1'b0;
    sh_reply <= 1'b0;
    n = 0;
    while (!(done | fb | tmo) && n < 2000)
    begin
      @(negedge clk);
      if (pca)
        io_seen = iop;
      n++;
    end
    cmp({tmo, fb, done}, 32'(1 << er));
    if (er == 0)
    begin
      cmp(cap_code, k);
      cmp(io_seen, ad[3]);
      if (k[1])
        cmp(cap_data, d);
      else
      begin
        cmp(rsp.word0, exp_word(ad));
        cmp(rsp.word1, exp_word(ad ^ 22'h000002));
        cmp(rsp.par_err, bad_par);
      end
    end
  endtask : op

  initial
  begin
    #500000;
    miscompares++;
    finish_test();
  end

  initial
  begin
    {rst_n, req_valid, ubmem, sh_sync, sh_reply, drop_sel, no_stb, bad_par} = '0;
    req  = '0;
    prev = pml_pkg::PML_PREV_NONE;
    busy = 5'h04;
    void'($urandom(32'h7798bea7));
    repeat (4) @(negedge clk);
    rst_n = 1'b1;
    for (int i = 0; i < 28; i++)
    begin
      busy = 5'($urandom % 20);
      op(2'($urandom), {1'b0, 20'($urandom), 1'b0}, 16'($urandom), 2'($urandom),
         ($urandom % 3) * 8, 0);
    end
    busy = 5'h1F;
    op(2'h3, 22'h00F2A4, 16'h5A01, 2'h0, 0, 0);
    op(2'h1, 22'h00F2A4, 16'h0000, 2'h0, 0, 0);
    op(2'h0, 22'h01E3F2, 16'h0000, 2'h2, 12, 0);
    ubmem = 1'b1;
    op(2'h0, 22'h000100, 16'h0000, 2'h0, 0, 1);
    ubmem = 1'b0;
    op(2'h2, 22'h200100, 16'h1234, 2'h0, 0, 1);
    drop_sel = 1'b1;
    op(2'h0, 22'h000200, 16'h0000, 2'h3, 8, 1);
    op(2'h2, 22'h000204, 16'hBEEF, 2'h0, 0, 1);
    drop_sel = 1'b0;
    no_stb = 1'b1;
    op(2'h1, 22'h000300, 16'h0000, 2'h0, 0, 2);
    no_stb = 1'b0;
    bad_par = 1'b1;
    op(2'h0, 22'h000402, 16'h0000, 2'h1, 16, 0);
    bad_par = 1'b0;
    op(2'h0, 22'h000406, 16'h0000, 2'h0, 0, 0);
    cmp(viol, 8'h00);
    finish_test();
  end
endmodule : pml_host_tb_top
